// ---- design/i2c_seq_pkg.sv ----
// package: register map, flag layout, states and carriers of the sequencer
// assumes: one 32-bit axi4-lite slave, byte-wide registers in the low lane
package i2c_seq_pkg;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [3:0] ctrl_addr = 4'h0;
  localparam logic [3:0] stat_addr = 4'h4;
  localparam logic [3:0] buf_addr = 4'h8;
  localparam logic [3:0] baud_addr = 4'hc;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int ctrl_rs_bit = 0;
  localparam int ctrl_stop_bit = 1;
  localparam int ctrl_ack_bit = 2;
  localparam int ctrl_ack_data_value_bit = 3;
  localparam int ctrl_ie_bit = 4;
  localparam int flg_start = 0;
  localparam int flg_stop = 1;
  localparam int flg_write_collision_flag = 2;
  localparam int flg_bcl = 3;
  localparam int flg_pif = 4;
  localparam int stat_bf_bit = 5;
  localparam int stat_ack_status_flag_bit = 6;
  localparam int stat_busy_bit = 7;
  localparam logic [7:0] baud_reset = 8'h04;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  localparam logic [3:0] last_bit = 4'h7;
  localparam logic [3:0] ack_bit = 4'h8;

  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  typedef enum logic [4:0] {
    st_idle = 5'h00,
    st_rs_scllo = 5'h01,
    st_rs_sdahi = 5'h02,
    st_rs_sclwt = 5'h03,
    st_rs_high = 5'h04,
    st_rs_sdalo = 5'h05,
    st_ak_low = 5'h06,
    st_ak_wait = 5'h07,
    st_ak_high = 5'h08,
    st_p_sdalo = 5'h09,
    st_p_low = 5'h0a,
    st_p_wait = 5'h0b,
    st_p_high = 5'h0c,
    st_p_sdawt = 5'h0d,
    st_p_done = 5'h0e,
    st_t_low = 5'h0f,
    st_t_wait = 5'h10,
    st_t_high = 5'h11
  } seq_state_t;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic scl;
    logic sda;
  } bus_pins_t;

  typedef struct packed {
    logic ld;
    logic run;
    logic [7:0] reload;
  } baud_ctl_t;

endpackage

// ---- design/pin_sync.sv ----
// two-flop synchroniser for the sampled bus lines
// assumes: lines are asynchronous to aclk; only stage two is read outside
`timescale 1ns/1ps
module pin_sync import i2c_seq_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // lines
  input wire bus_pins_t pins_in,
  output bus_pins_t pins_out
);

  typedef struct packed {
    bus_pins_t meta;
    bus_pins_t sync;
  } sync_state_t;

  sync_state_t s_r;
  sync_state_t s_nxt;

  always_comb begin
    s_nxt.meta = pins_in;
    s_nxt.sync = s_r.meta;
  end

  // ----------------------------------------
  // idle bus reads high
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pins_out = s_r.sync;

endmodule // pin_sync

// ---- design/baud_counter.sv ----
// baud period down-counter with load, pause and expiry
// assumes: load and run come from the sequencer on the same clock
`timescale 1ns/1ps
module baud_counter import i2c_seq_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire baud_ctl_t ctl,
  // expiry
  output logic expired
);

  typedef struct packed {
    logic [7:0] cnt;
  } baud_state_t;

  baud_state_t s_r;
  baud_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (ctl.ld) begin
      s_nxt.cnt = ctl.reload;
    end else if (ctl.run && s_r.cnt != 8'h00) begin
      s_nxt.cnt = s_r.cnt - 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // expiry only while running
  // ----------------------------------------
  assign expired = ctl.run && !ctl.ld && s_r.cnt == 8'h00;

endmodule // baud_counter

// ---- design/i2c_host_condition_sequencer.sv ----
// host sequencer: repeated start, acknowledge, stop and byte transmit
// assumes: open-drain scl/sda resolved outside; axi4-lite master on aclk
//
// Overview of operation
// - repeated start: scl low, sda released
// - then release scl, high, sda low, scl low
// - repeated start ends self-cleared, sda held low
// - repeated start ignored while busy
// - repeated start collisions on sda or scl
// - collision aborts, releases lines, clears requests
// - ack sequence drives ack data value
// - ack: one period low, high, then idle
// - buffer write during ack: write collision
// - scl held low after ninth clock
// - stop: sda low, scl high, sda high
// - stop seen, then interrupt one period later
// - buffer write during stop: write collision
// - sleep: completed event raises wake when enabled
// - reset disables port, abandons transfer
// - buffer write sets full, starts transmit
// - bits change after scl falls, one period each
// - after eighth clock clear full, release sda
// - ninth bit captured as ack status
// - after ninth clock interrupt, hold scl low
// - buffer write while shifting: write collision
// - counter pauses until scl reads high
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module i2c_host_condition_sequencer import i2c_seq_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // two-wire bus
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // power state
  input wire logic sleep_i,
  output logic wake_event
);

  typedef struct packed {
    seq_state_t fsm;
    logic repeated_start_request;
    logic stop_condition_request;
    logic ack_sequence_request;
    logic ack_data_value;
    logic ie;
    logic bf;
    logic ack_status_flag;
    logic [4:0] flg;
    logic scl_low;
    logic sda_low;
    logic sda_q;
    logic [7:0] shreg;
    logic [7:0] bufv;
    logic [3:0] bitn;
    logic [7:0] reload;
    logic ld;
    logic aw_ok;
    logic [3:0] aw_a;
    logic w_ok;
    logic [7:0] w_d;
    logic w_lane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic wake;
  } seq_reg_t;

  seq_reg_t s_r;
  seq_reg_t s_nxt;
  bus_pins_t pins;
  baud_ctl_t bctl;
  logic expired;
  logic wr_fire;
  logic busy;

  // ----------------------------------------
  // line sampling and baud counter
  // ----------------------------------------
  pin_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pins_in('{scl: scl_i, sda: sda_i}),
    .pins_out(pins)
  );

  always_comb begin
    bctl.ld = s_r.ld;
    bctl.reload = s_r.reload;
    // paused in idle and in the wait states until the awaited scl or sda level is seen
    bctl.run = !(s_r.fsm inside {st_idle, st_rs_scllo, st_rs_sclwt, st_ak_wait,
                 st_p_sdalo, st_p_wait, st_p_sdawt, st_t_wait});
  end

  baud_counter u_baud (
    .aclk(aclk),
    .aresetn(aresetn),
    .ctl(bctl),
    .expired(expired)
  );

  assign wr_fire = s_r.aw_ok && s_r.w_ok && !s_r.bvalid;
  assign busy = s_r.fsm != st_idle || s_r.repeated_start_request || s_r.stop_condition_request || s_r.ack_sequence_request;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [4:0] evt;
    logic [4:0] clr;
    logic bcl;
    evt = '0;
    clr = '0;
    bcl = 1'b0;
    s_nxt = s_r;
    s_nxt.ld = 1'b0;
    s_nxt.wake = 1'b0;
    s_nxt.sda_q = pins.sda;
    // start and stop seen on the lines
    if (pins.scl && s_r.sda_q && !pins.sda) evt[flg_start] = 1'b1;
    if (pins.scl && !s_r.sda_q && pins.sda) evt[flg_stop] = 1'b1;

    unique case (s_r.fsm)
      st_idle: begin
      end
      st_rs_scllo: if (!pins.scl) begin
        s_nxt.ld = 1'b1;
        s_nxt.sda_low = 1'b0;
        s_nxt.fsm = st_rs_sdahi;
      end
      st_rs_sdahi: if (expired) begin
        if (pins.sda) begin
          s_nxt.scl_low = 1'b0;
          s_nxt.fsm = st_rs_sclwt;
        end else begin
          bcl = 1'b1;
        end
      end
      st_rs_sclwt: if (pins.scl) begin
        if (!pins.sda) begin
          bcl = 1'b1;
        end else begin
          s_nxt.ld = 1'b1;
          s_nxt.fsm = st_rs_high;
        end
      end
      st_rs_high: begin
        if (!pins.scl) begin
          bcl = 1'b1;
        end else if (expired) begin
          s_nxt.sda_low = 1'b1;
          s_nxt.ld = 1'b1;
          s_nxt.fsm = st_rs_sdalo;
        end
      end
      st_rs_sdalo: if (expired) begin
        // no reload, sda stays low
        s_nxt.scl_low = 1'b1;
        s_nxt.repeated_start_request = 1'b0;
        evt[flg_pif] = 1'b1;
        s_nxt.fsm = st_idle;
      end
      st_ak_low: if (expired) begin
        s_nxt.scl_low = 1'b0;
        s_nxt.fsm = st_ak_wait;
      end
      st_ak_wait: if (pins.scl) begin
        s_nxt.ld = 1'b1;
        s_nxt.fsm = st_ak_high;
      end
      st_ak_high: begin
        if (!s_r.sda_low && !pins.sda) begin
          bcl = 1'b1;
        end else if (expired) begin
          s_nxt.scl_low = 1'b1;
          s_nxt.ack_sequence_request = 1'b0;
          evt[flg_pif] = 1'b1;
          s_nxt.fsm = st_idle;
        end
      end
      st_p_sdalo: if (!pins.sda) begin
        s_nxt.ld = 1'b1;
        s_nxt.fsm = st_p_low;
      end
      st_p_low: if (expired) begin
        s_nxt.scl_low = 1'b0;
        s_nxt.fsm = st_p_wait;
      end
      st_p_wait: if (pins.scl) begin
        s_nxt.ld = 1'b1;
        s_nxt.fsm = st_p_high;
      end
      st_p_high: if (expired) begin
        s_nxt.sda_low = 1'b0;
        s_nxt.fsm = st_p_sdawt;
      end
      st_p_sdawt: if (pins.sda && pins.scl) begin
        s_nxt.ld = 1'b1;
        s_nxt.fsm = st_p_done;
      end
      st_p_done: if (expired) begin
        s_nxt.stop_condition_request = 1'b0;
        evt[flg_pif] = 1'b1;
        s_nxt.fsm = st_idle;
      end
      st_t_low: if (expired) begin
        s_nxt.scl_low = 1'b0;
        s_nxt.fsm = st_t_wait;
      end
      st_t_wait: if (pins.scl) begin
        if (s_r.bitn == ack_bit) s_nxt.ack_status_flag = pins.sda;
        s_nxt.ld = 1'b1;
        s_nxt.fsm = st_t_high;
      end
      st_t_high: begin
        if (s_r.bitn != ack_bit && !s_r.sda_low && !pins.sda) begin
          bcl = 1'b1;
        end else if (expired) begin
          s_nxt.scl_low = 1'b1;
          if (s_r.bitn == ack_bit) begin
            // clock parked low until the next byte
            evt[flg_pif] = 1'b1;
            s_nxt.fsm = st_idle;
          end else begin
            if (s_r.bitn == last_bit) s_nxt.bf = 1'b0;
            s_nxt.sda_low = s_r.bitn == last_bit ? 1'b0 : !s_r.shreg[6];
            s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
            s_nxt.bitn = s_r.bitn + 4'h1;
            s_nxt.ld = 1'b1;
            s_nxt.fsm = st_t_low;
          end
        end
      end
      default: s_nxt.fsm = st_idle;
    endcase

    // abort on collision
    if (bcl) begin
      s_nxt.fsm = st_idle;
      s_nxt.scl_low = 1'b0;
      s_nxt.sda_low = 1'b0;
      s_nxt.repeated_start_request = 1'b0;
      s_nxt.stop_condition_request = 1'b0;
      s_nxt.ack_sequence_request = 1'b0;
      s_nxt.bf = 1'b0;
      evt[flg_bcl] = 1'b1;
    end

    // ----------------------------------------
    // axi4-lite slave
    // ----------------------------------------
    if (awvalid && awready) begin
      s_nxt.aw_ok = 1'b1;
      s_nxt.aw_a = awaddr;
    end
    if (wvalid && wready) begin
      s_nxt.w_ok = 1'b1;
      s_nxt.w_d = wdata[7:0];
      s_nxt.w_lane = wstrb[0];
    end
    if (s_r.bvalid && bready) s_nxt.bvalid = 1'b0;
    if (wr_fire) begin
      s_nxt.aw_ok = 1'b0;
      s_nxt.w_ok = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = resp_okay;
      unique case ({s_r.aw_a[3:2], 2'b00})
        ctrl_addr: if (s_r.w_lane) begin
          s_nxt.ack_data_value = s_r.w_d[ctrl_ack_data_value_bit];
          s_nxt.ie = s_r.w_d[ctrl_ie_bit];
          // requests only from idle, one at a time
          if (!busy) begin
            if (s_r.w_d[ctrl_rs_bit]) begin
              s_nxt.repeated_start_request = 1'b1;
              s_nxt.scl_low = 1'b1;
              s_nxt.fsm = st_rs_scllo;
            end else if (s_r.w_d[ctrl_stop_bit]) begin
              s_nxt.stop_condition_request = 1'b1;
              s_nxt.sda_low = 1'b1;
              s_nxt.fsm = st_p_sdalo;
            end else if (s_r.w_d[ctrl_ack_bit]) begin
              s_nxt.ack_sequence_request = 1'b1;
              s_nxt.scl_low = 1'b1;
              s_nxt.sda_low = !s_r.w_d[ctrl_ack_data_value_bit];
              s_nxt.ld = 1'b1;
              s_nxt.fsm = st_ak_low;
            end
          end
        end
        stat_addr: if (s_r.w_lane) clr = s_r.w_d[4:0];
        buf_addr: if (s_r.w_lane) begin
          if (busy) begin
            evt[flg_write_collision_flag] = 1'b1;
          end else begin
            s_nxt.bufv = s_r.w_d;
            s_nxt.shreg = s_r.w_d;
            s_nxt.bf = 1'b1;
            s_nxt.bitn = 4'h0;
            s_nxt.scl_low = 1'b1;
            s_nxt.sda_low = !s_r.w_d[7];
            s_nxt.ld = 1'b1;
            s_nxt.fsm = st_t_low;
          end
        end
        baud_addr: if (s_r.w_lane) s_nxt.reload = s_r.w_d;
        default: s_nxt.bresp = resp_slverr;
      endcase
    end
    if (arvalid && arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = resp_okay;
      unique case ({araddr[3:2], 2'b00})
        ctrl_addr: s_nxt.rdata = {3'h0, s_r.ie, s_r.ack_data_value, s_r.ack_sequence_request, s_r.stop_condition_request, s_r.repeated_start_request};
        stat_addr: s_nxt.rdata = {busy, s_r.ack_status_flag, s_r.bf, s_r.flg};
        buf_addr: s_nxt.rdata = s_r.bufv;
        baud_addr: s_nxt.rdata = s_r.reload;
        default: begin
          s_nxt.rdata = 8'h00;
          s_nxt.rresp = resp_slverr;
        end
      endcase
    end else if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end

    // set wins over a clear in the same cycle
    s_nxt.flg = (s_r.flg & ~clr) | evt;
    s_nxt.wake = sleep_i && s_r.ie && (evt[flg_pif] || evt[flg_bcl]);
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '{fsm: st_idle, reload: baud_reset, sda_q: 1'b1, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign awready = !s_r.aw_ok && !s_r.bvalid;
  assign wready = !s_r.w_ok && !s_r.bvalid;
  assign bvalid = s_r.bvalid;
  assign bresp = s_r.bresp;
  assign arready = !s_r.rvalid;
  assign rvalid = s_r.rvalid;
  assign rresp = s_r.rresp;
  assign rdata = {24'h000000, s_r.rdata};
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_n = !s_r.scl_low;
  assign sda_oe_n = !s_r.sda_low;
  assign wake_event = s_r.wake;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_rs_finish: assert property (s_r.fsm == st_rs_sdalo && expired |=>
    !s_r.repeated_start_request && !scl_oe_n && !sda_oe_n && s_r.flg[flg_pif])
    else $error("repeated start did not finish cleanly");
  a_rs_ignored: assert property (wr_fire && s_r.aw_a == ctrl_addr && busy |=>
    s_r.fsm != st_rs_scllo || $past(s_r.fsm) == st_rs_scllo)
    else $error("repeated start taken while busy");
  a_bcl_abort: assert property ($rose(s_r.flg[flg_bcl]) |-> scl_oe_n && sda_oe_n &&
    !s_r.repeated_start_request && !s_r.stop_condition_request && !s_r.ack_sequence_request && s_r.fsm == st_idle)
    else $error("collision did not abort");
  a_ack_drive: assert property (s_r.fsm == st_ak_low |->
    !scl_oe_n && sda_oe_n == s_r.ack_data_value)
    else $error("ack data not driven");
  a_write_collision_flag_busy: assert property (wr_fire && s_r.aw_a == buf_addr && s_r.w_lane && busy |=>
    s_r.flg[flg_write_collision_flag] && s_r.bufv == $past(s_r.bufv))
    else $error("buffer write while busy not refused");
  a_bf_load: assert property (wr_fire && s_r.aw_a == buf_addr && s_r.w_lane && !busy |=>
    s_r.bf && s_r.fsm == st_t_low && !scl_oe_n)
    else $error("buffer write did not start transfer");
  a_byte_end: assert property (s_r.fsm == st_t_high && s_r.bitn == ack_bit && expired
    |=> s_r.fsm == st_idle && !scl_oe_n && sda_oe_n ##1 !scl_oe_n)
    else $error("clock not parked low after ninth bit");
  a_ack_status_flag_cap: assert property (s_r.fsm == st_t_wait && s_r.bitn == ack_bit && pins.scl
    |=> s_r.ack_status_flag == $past(pins.sda))
    else $error("ack status not captured");
  a_scl_pause: assert property (s_r.fsm inside {st_t_wait, st_ak_wait, st_p_wait} &&
    !pins.scl |=> s_r.fsm == $past(s_r.fsm))
    else $error("sequence moved before scl high");
  a_stop_end: assert property (s_r.fsm == st_p_done && expired |=>
    !s_r.stop_condition_request && s_r.flg[flg_pif] && s_r.fsm == st_idle)
    else $error("stop did not complete");

endmodule // i2c_host_condition_sequencer

// ---- testbench/i2c_client_model.sv ----
// client device model on the two-wire bus: shifts in bytes, answers the ninth bit
// assumes: lines resolved by the bench with pull-ups; host makes scl
`timescale 1ns/1ps
module i2c_client_model (
  // lines
  input wire logic scl,
  input wire logic sda,
  // behaviour
  input wire logic nack,
  input wire logic jam_sda,
  // outputs
  output logic sda_pull_n,
  output logic [7:0] rx_byte
);
  // ----------------------------------------
  // bit counting and acknowledge
  // ----------------------------------------
  int bit_n = 0;
  logic ack_drv = 1'h0;
  initial rx_byte = 8'h00;
  // start or stop resets the frame; settle first so that a bit change
  // in the same step as a falling clock is not taken for a condition
  always @(sda) begin
    #1;
    if (scl === 1'h1) bit_n = 0;
  end
  always @(posedge scl) begin
    if (bit_n == 9) bit_n = 0;
    if (bit_n < 8) rx_byte = {rx_byte[6:0], sda};
    bit_n = bit_n + 1;
  end
  // pull data low during the ninth bit unless told to refuse
  always @(negedge scl) begin
    ack_drv = (bit_n == 8) && !nack;
  end
  assign sda_pull_n = !(ack_drv || jam_sda);
endmodule // i2c_client_model

// ---- testbench/test_i2c_host_condition_sequencer.sv ----
// testbench: sequencer against a client model, driven over axi4-lite
// assumes: design package compiled first; both lines pulled up here
`timescale 1ns/1ps
module test_i2c_host_condition_sequencer import i2c_seq_pkg::*; ;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, sleep_i = 1'h0, nack = 1'h0, jam = 1'h0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic awready, wready, bvalid, arready, rvalid, scl_o, scl_oe_n, sda_o, sda_oe_n;
  logic wake_event, pull_n;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] rx;
  int n_mismatch = 0, cmp_count = 0, wakes = 0;
  wire scl = (scl_oe_n === 1'h0) ? scl_o : 1'h1;
  wire sda = ((sda_oe_n === 1'h0) ? sda_o : 1'h1) & pull_n;

  i2c_host_condition_sequencer DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'h1), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .sleep_i(sleep_i), .wake_event(wake_event));
  i2c_client_model client (.scl(scl), .sda(sda), .nack(nack), .jam_sda(jam),
    .sda_pull_n(pull_n), .rx_byte(rx));

  always #25 aclk = ~aclk;
  always @(posedge aclk) begin
    if (wake_event === 1'h1) wakes++;
  end

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic ta, tw, tb;
    int n;
    n = 0;
    tb = 1'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!tb && n < 100) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      resp = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      if (tb) bready <= 1'h0;
      n++;
    end
    chk(tb, 1'h1, "write answered");
  endtask

  task automatic rd(input logic [3:0] a);
    logic ta, tr;
    int n;
    n = 0;
    tr = 1'h0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!tr && n < 100) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      q = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'h0;
      if (tr) rready <= 1'h0;
      n++;
    end
    chk(tr, 1'h1, "read answered");
  endtask

  task automatic wait_flag(input int b);
    int n;
    n = 0;
    do begin
      rd(stat_addr);
      n++;
    end while (q[b] !== 1'h1 && n < 300);
    chk(q[b], 1'h1, "flag raised");
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    rd(baud_addr);
    chk(q, {24'h0, baud_reset}, "baud reset");
    chk(resp, resp_okay, "read okay");
    rd(stat_addr);
    chk(q, 32'h0, "status reset");
    chk({scl_oe_n, sda_oe_n}, 2'h3, "lines idle");
    wr(4'h2, 8'h00);
    chk(resp, resp_okay, "aliased write");
    wr(baud_addr, 8'h03);
    rd(baud_addr);
    chk(q, 32'h3, "baud written");
    $display("test regs done");
  endtask

  task automatic t_byte(input logic [7:0] d, input logic nk);
    nack <= nk;
    wr(buf_addr, d);
    rd(stat_addr);
    chk(q[stat_bf_bit], 1'h1, "buffer full");
    wr(buf_addr, ~d);
    rd(buf_addr);
    chk(q, {24'h0, d}, "buffer kept");
    wait_flag(flg_pif);
    chk(q, {24'h0, 1'h0, nk, 6'h14}, "status after byte");
    chk(rx, d, "bits on wire");
    repeat (20) @(posedge aclk);
    chk({scl_oe_n, sda_oe_n}, 2'h1, "clock held low");
    wr(stat_addr, 8'h1f);
    $display("test byte %h done", d);
  endtask

  task automatic t_ack(input logic dt);
    int n;
    n = 0;
    wr(ctrl_addr, {4'h0, dt, 3'h4});
    wr(ctrl_addr, {4'h0, dt, 3'h5});
    wr(buf_addr, 8'h5a);
    while (scl_oe_n !== 1'h1 && n < 200) begin
      @(negedge aclk);
      n++;
    end
    chk(n < 200, 1'h1, "clock released");
    chk(sda_oe_n, dt, "ack value");
    wait_flag(flg_pif);
    chk(q, 32'h54, "ack status");
    rd(ctrl_addr);
    chk(q, {28'h0, dt, 3'h0}, "ack request cleared");
    chk(scl_oe_n, 1'h0, "clock low after ack");
    wr(stat_addr, 8'h1f);
    $display("test ack %h done", dt);
  endtask

  task automatic t_rs();
    wr(ctrl_addr, 8'h01);
    wait_flag(flg_pif);
    chk(q, 32'h51, "start seen");
    rd(ctrl_addr);
    chk(q, 32'h0, "restart cleared");
    chk({scl_oe_n, sda_oe_n}, 2'h0, "both held low");
    wr(stat_addr, 8'h1f);
    $display("test restart done");
  endtask

  task automatic t_stop();
    sleep_i <= 1'h1;
    wr(ctrl_addr, 8'h12);
    wr(buf_addr, 8'h33);
    wait_flag(flg_pif);
    chk(q, 32'h16, "stop seen");
    rd(ctrl_addr);
    chk(q, 32'h10, "stop cleared");
    chk({scl_oe_n, sda_oe_n}, 2'h3, "lines released");
    chk(wakes, 1, "wake pulse");
    wr(stat_addr, 8'h1f);
    $display("test stop done");
  endtask

  task automatic t_coll();
    int n;
    n = 0;
    wr(ctrl_addr, 8'h1c);
    while (scl_oe_n !== 1'h0 && n < 200) begin
      @(posedge aclk);
      n++;
    end
    jam <= 1'h1;
    wait_flag(flg_bcl);
    rd(ctrl_addr);
    chk(q, 32'h18, "requests cleared");
    chk({scl_oe_n, sda_oe_n}, 2'h3, "lines released");
    chk(wakes, 2, "wake on collision");
    jam <= 1'h0;
    wr(stat_addr, 8'h1f);
    $display("test collision done");
  endtask

  task automatic t_reset();
    wr(buf_addr, 8'hc3);
    repeat (30) @(posedge aclk);
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (4) @(posedge aclk);
    chk({scl_oe_n, sda_oe_n}, 2'h3, "transfer abandoned");
    rd(stat_addr);
    chk(q, 32'h0, "status after reset");
    $display("test reset done");
  endtask

  // ----------------------------------------
  // sequence and verdict
  // ----------------------------------------
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_byte(8'ha4, 1'h0);
    t_byte(8'h3c, 1'h1);
    wr(baud_addr, 8'h0f);
    t_ack(1'h0);
    t_ack(1'h1);
    t_rs();
    t_byte(8'h5b, 1'h0);
    t_stop();
    t_coll();
    t_reset();
    finish_test();
  end

  initial begin
    #2000000;
    n_mismatch++;
    finish_test();
  end
endmodule // test_i2c_host_condition_sequencer
